// file: rtl/rcdv_regs.vh
// Constants for the receive configuration and data valid block.
// Assumes a 200 MHz system clock that also serves as the crystal timebase.
`ifndef RCDV_REGS_VH
`define RCDV_REGS_VH

// Register subaddresses (write side and read side)
`define RCDV_ADDR_MAIN 8'h00
`define RCDV_ADDR_FILT 8'h03
`define RCDV_ADDR_MODE 8'h0B
`define RCDV_ADDR_WMIN 8'h0C
`define RCDV_ADDR_WMAX 8'h0D
`define RCDV_ADDR_RSSI 8'h0E
`define RCDV_ADDR_PER 8'h0F
`define RCDV_ADDR_MEAS 8'h80
`define RCDV_ADDR_STAT 8'h81

// Field positions in main_setup
`define RCDV_MAIN_PA_BIT 0
`define RCDV_MAIN_GAIN_BIT 4
`define RCDV_MAIN_TRX_BIT 10
`define RCDV_MAIN_MOD_BIT 11
`define RCDV_MAIN_PWD_BIT 14
`define RCDV_MAIN_SLICE_BIT 15

// Field positions in filter_setup
`define RCDV_FILT_CH_LSB 1
`define RCDV_FILT_CH_MSB 3
`define RCDV_FILT_DF_LSB 4
`define RCDV_FILT_DF_MSB 7

// Reset values
`define RCDV_MAIN_RST 16'h0011
`define RCDV_FILT_RST 8'h00
`define RCDV_MODE_RST 2'h0
`define RCDV_WMIN_RST 16'h0000
`define RCDV_WMAX_RST 16'hFFFF
`define RCDV_RSSI_RST 8'h80
`define RCDV_PER_RST 16'h1000

// Divider chain ratios
`define RCDV_DIV_TX 4'h6
`define RCDV_DIV_RX 4'h8

// Wake sequencer operating modes
`define RCDV_MODE_SLAVE 2'h0
`define RCDV_MODE_POLL 2'h1
`define RCDV_MODE_TIMER 2'h2

// Timer mode interrupt pulse: time in ns and derived cycle count
`define RCDV_CLK_MHZ 200
`define RCDV_TPULSE_NS 100
`define RCDV_TPULSE_CYC ((`RCDV_TPULSE_NS * `RCDV_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/rcdv_rate_win.v
// Data-rate window counter: counts clock cycles between rising edges of the sliced data.
// Assumes sliced data is synchronous to clk_i; the clock is the crystal timebase.
module rcdv_rate_win (
    input wire clk_i,
    input wire sys_rst_i,
    input wire enable_i,
    input wire sliced_data_i,
    input wire [15:0] win_min_i,
    input wire [15:0] win_max_i,
    output reg [15:0] period_o,
    output reg rate_ok_o
);
    reg data_d;
    reg [15:0] cnt;
    wire rise;

    assign rise = sliced_data_i & ~data_d;

    // Gate the count by data edges; saturate so a stalled line never wraps into the window
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_d <= 1'b0;
            cnt <= 16'h0000;
            period_o <= 16'h0000;
            rate_ok_o <= 1'b0;
        end else if (!enable_i) begin
            data_d <= sliced_data_i;
            cnt <= 16'h0000;
            rate_ok_o <= 1'b0;
        end else begin
            data_d <= sliced_data_i;
            if (rise) begin
                period_o <= cnt; // RULE10
                rate_ok_o <= (cnt >= win_min_i) && (cnt <= win_max_i); // RULE10
                cnt <= 16'h0001;
            end else if (cnt != 16'hFFFF) begin
                cnt <= cnt + 16'h0001;
            end else begin
                rate_ok_o <= 1'b0; // Line went quiet: no valid rate
            end
        end
    end
endmodule // rcdv_rate_win

// file: rtl/rcdv_top.v
// Receive path configuration registers, wake sequencer and data valid detector.
// Assumes the serial bus front end delivers decoded register writes and reads,
// and that all inputs are synchronous to clk_i.
// Functional notes
// (RULE1) main_setup bit 4 picks front amp gain, 1 high, resets to 1.
// (RULE2) Divider ratio 6 for transmit, 8 for receive, from select pin and bit 10.
// (RULE3) Channel filter bandwidth code from filter_setup bits 1 to 3.
// (RULE4) Data filter bandwidth code from filter_setup bits 4 to 7.
// (RULE5) Demodulated or amplitude path chosen by modulation pin and bit 11.
// (RULE6) Bit 15 picks slicer threshold: 0 RC lowpass, 1 peak detectors; resets 0.
// (RULE7) Power down when the pin requests it or bit 14 is set.
// (RULE8) Pin high means power down, pin low means device on.
// (RULE9) Wake sequencer offers slave, self polling and timer modes.
// (RULE10) Window counter measures data period in clocks and checks expected range.
// (RULE11) Signal strength compared against configured expected level.
// (RULE12) Self polling with both conditions true pulls the pin low.
// (RULE13) Pin is open drain only; outside party may pull it low too.
// (RULE14) Registers are writable and readable in every operating state.
// (RULE15) Window limits and strength threshold come from configuration registers.
`include "rcdv_regs.vh"
module rcdv_top (
    input wire clk_i,
    input wire sys_rst_i,
    input wire reg_wr_i,
    input wire [7:0] reg_waddr_i,
    input wire [15:0] reg_wdata_i,
    input wire [7:0] reg_raddr_i,
    output reg [15:0] reg_rdata_o,
    input wire tx_rx_select_pin_i,
    input wire modulation_select_pin_i,
    input wire powerdown_detect_pin_i,
    output reg powerdown_detect_pin_o,
    output reg powerdown_detect_pin_oe_n_o,
    input wire sliced_data_i,
    input wire [7:0] rssi_level_i,
    output reg front_amp_gain_sel_o,
    output reg pa_high_power_o,
    output reg [3:0] div_ratio_o,
    output reg amp_path_sel_o,
    output reg slicer_peak_sel_o,
    output reg [2:0] chan_bw_code_o,
    output reg [3:0] data_bw_code_o,
    output reg powerdown_o,
    output reg data_valid_o
);
    localparam ST_SLAVE = 3'd0;
    localparam ST_OFF = 3'd1;
    localparam ST_ON = 3'd2;
    localparam ST_DETECT = 3'd3;
    localparam ST_TWAIT = 3'd4;
    localparam ST_TPULSE = 3'd5;
    // Pulse count cut to the timer width on purpose; its value is far below 16 bits
    localparam [31:0] TPULSE_FULL = `RCDV_TPULSE_CYC;
    localparam [15:0] TPULSE_CYC = TPULSE_FULL[15:0];

    reg [15:0] main_setup;
    reg [7:0] filter_setup;
    reg [1:0] wake_mode;
    reg [15:0] win_min;
    reg [15:0] win_max;
    reg [7:0] rssi_thresh;
    reg [15:0] poll_period;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [15:0] tmr;
    reg [15:0] next_tmr;
    reg rssi_ok;
    reg [15:0] next_rdata;
    wire [15:0] meas_period;
    wire rate_ok;
    wire meas_en;
    wire valid_now;

    // Decode shared by the write and read paths
    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // Configuration writes are taken in any state, including power down
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            main_setup <= `RCDV_MAIN_RST; // RULE1 RULE6
            filter_setup <= `RCDV_FILT_RST;
            wake_mode <= `RCDV_MODE_RST;
            win_min <= `RCDV_WMIN_RST;
            win_max <= `RCDV_WMAX_RST;
            rssi_thresh <= `RCDV_RSSI_RST;
            poll_period <= `RCDV_PER_RST;
        end else if (reg_wr_i) begin
            if (hit(reg_waddr_i, `RCDV_ADDR_MAIN)) main_setup <= reg_wdata_i; // RULE14
            if (hit(reg_waddr_i, `RCDV_ADDR_FILT)) filter_setup <= reg_wdata_i[7:0];
            if (hit(reg_waddr_i, `RCDV_ADDR_MODE)) wake_mode <= reg_wdata_i[1:0];
            if (hit(reg_waddr_i, `RCDV_ADDR_WMIN)) win_min <= reg_wdata_i; // RULE15
            if (hit(reg_waddr_i, `RCDV_ADDR_WMAX)) win_max <= reg_wdata_i; // RULE15
            if (hit(reg_waddr_i, `RCDV_ADDR_RSSI)) rssi_thresh <= reg_wdata_i[7:0]; // RULE15
            if (hit(reg_waddr_i, `RCDV_ADDR_PER)) poll_period <= reg_wdata_i;
        end
    end

    // Measurement only runs in the polling on and detect states (ST_ON, ST_DETECT)
    assign meas_en = (state == ST_ON) || (state == ST_DETECT);

    rcdv_rate_win u_rate (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(meas_en),
        .sliced_data_i(sliced_data_i),
        .win_min_i(win_min),
        .win_max_i(win_max),
        .period_o(meas_period),
        .rate_ok_o(rate_ok)
    );

    // Strength compare is registered to line up with the rate result
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rssi_ok <= 1'b0;
        end else begin
            rssi_ok <= meas_en && (rssi_level_i >= rssi_thresh); // RULE11
        end
    end

    assign valid_now = rate_ok & rssi_ok;

    // Wake sequencer; a mode write takes effect from any state
    always @* begin
        next_state = state;
        next_tmr = tmr;
        case (state)
            ST_SLAVE: begin
                if (wake_mode == `RCDV_MODE_POLL) begin // RULE9
                    next_state = ST_OFF;
                    next_tmr = poll_period;
                end else if (wake_mode == `RCDV_MODE_TIMER) begin // RULE9
                    next_state = ST_TWAIT;
                    next_tmr = poll_period;
                end
            end
            ST_OFF: begin
                if (wake_mode != `RCDV_MODE_POLL) begin
                    next_state = ST_SLAVE;
                end else if (tmr <= 16'h0001) begin
                    next_state = ST_ON;
                    next_tmr = poll_period;
                end else begin
                    next_tmr = tmr - 16'h0001;
                end
            end
            ST_ON: begin
                if (wake_mode != `RCDV_MODE_POLL) begin
                    next_state = ST_SLAVE;
                end else if (valid_now) begin
                    next_state = ST_DETECT; // RULE12
                end else if (tmr <= 16'h0001) begin
                    next_state = ST_OFF;
                    next_tmr = poll_period;
                end else begin
                    next_tmr = tmr - 16'h0001;
                end
            end
            ST_DETECT: begin
                // Hold the interrupt while valid data lasts, then resume polling
                if (wake_mode != `RCDV_MODE_POLL) begin
                    next_state = ST_SLAVE;
                end else if (!valid_now) begin
                    next_state = ST_OFF;
                    next_tmr = poll_period;
                end
            end
            ST_TWAIT: begin
                if (wake_mode != `RCDV_MODE_TIMER) begin
                    next_state = ST_SLAVE;
                end else if (tmr <= 16'h0001) begin
                    next_state = ST_TPULSE;
                    next_tmr = TPULSE_CYC;
                end else begin
                    next_tmr = tmr - 16'h0001;
                end
            end
            ST_TPULSE: begin
                if (wake_mode != `RCDV_MODE_TIMER) begin
                    next_state = ST_SLAVE;
                end else if (tmr <= 16'h0001) begin
                    next_state = ST_TWAIT;
                    next_tmr = poll_period;
                end else begin
                    next_tmr = tmr - 16'h0001;
                end
            end
            default: begin
                next_state = ST_SLAVE;
                next_tmr = 16'h0000;
            end
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_SLAVE;
            tmr <= 16'h0000;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
        end
    end

    // Open drain pin: only ever drives low, pull-up gives the high level.
    // An outside low on the pin is simply read back as device on.
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            powerdown_detect_pin_o <= 1'b0;
            powerdown_detect_pin_oe_n_o <= 1'b1;
            data_valid_o <= 1'b0;
        end else begin
            powerdown_detect_pin_o <= 1'b0; // RULE13
            powerdown_detect_pin_oe_n_o <= !((next_state == ST_DETECT) ||
                (next_state == ST_TPULSE)); // RULE12 RULE13
            data_valid_o <= (next_state == ST_DETECT);
        end
    end

    // Analog control outputs decoded from the setup registers and pins
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            front_amp_gain_sel_o <= 1'b1;
            pa_high_power_o <= 1'b1;
            div_ratio_o <= `RCDV_DIV_RX;
            amp_path_sel_o <= 1'b0;
            slicer_peak_sel_o <= 1'b0;
            chan_bw_code_o <= 3'h0;
            data_bw_code_o <= 4'h0;
            powerdown_o <= 1'b1;
        end else begin
            front_amp_gain_sel_o <= main_setup[`RCDV_MAIN_GAIN_BIT]; // RULE1
            pa_high_power_o <= main_setup[`RCDV_MAIN_PA_BIT];
            div_ratio_o <= (tx_rx_select_pin_i | main_setup[`RCDV_MAIN_TRX_BIT]) ?
                `RCDV_DIV_TX : `RCDV_DIV_RX; // RULE2
            amp_path_sel_o <= modulation_select_pin_i |
                main_setup[`RCDV_MAIN_MOD_BIT]; // RULE5
            slicer_peak_sel_o <= main_setup[`RCDV_MAIN_SLICE_BIT]; // RULE6
            chan_bw_code_o <= filter_setup[`RCDV_FILT_CH_MSB:`RCDV_FILT_CH_LSB]; // RULE3
            data_bw_code_o <= filter_setup[`RCDV_FILT_DF_MSB:`RCDV_FILT_DF_LSB]; // RULE4
            // Polling off phase also sleeps; a high pin or bit 14 powers down in every state
            powerdown_o <= powerdown_detect_pin_i | main_setup[`RCDV_MAIN_PWD_BIT] |
                (next_state == ST_OFF); // RULE7 RULE8
        end
    end

    // Read mux; unmapped subaddresses read zero
    always @* begin
        next_rdata = 16'h0000;
        if (hit(reg_raddr_i, `RCDV_ADDR_MAIN)) next_rdata = main_setup;
        if (hit(reg_raddr_i, `RCDV_ADDR_FILT)) next_rdata = {8'h00, filter_setup};
        if (hit(reg_raddr_i, `RCDV_ADDR_MODE)) next_rdata = {14'h0000, wake_mode};
        if (hit(reg_raddr_i, `RCDV_ADDR_WMIN)) next_rdata = win_min;
        if (hit(reg_raddr_i, `RCDV_ADDR_WMAX)) next_rdata = win_max;
        if (hit(reg_raddr_i, `RCDV_ADDR_RSSI)) next_rdata = {8'h00, rssi_thresh};
        if (hit(reg_raddr_i, `RCDV_ADDR_PER)) next_rdata = poll_period;
        if (hit(reg_raddr_i, `RCDV_ADDR_MEAS)) next_rdata = meas_period;
        if (hit(reg_raddr_i, `RCDV_ADDR_STAT)) next_rdata = {11'h000, state, rssi_ok, rate_ok};
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else begin
            reg_rdata_o <= next_rdata; // RULE14
        end
    end
endmodule // rcdv_top

// file: dv/rcdv_mcu_model.sv
// Microcontroller side of the shared power-down/detect wire.
// Assumes the device only ever sinks the wire; the pull-up sits here.
module rcdv_mcu_model (
    input wire logic pull_low_i,
    input wire logic dev_oe_n_i,
    input wire logic dev_drive_i,
    output wire logic pin_level_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Wired-AND with pull-up: either party may sink it, nobody drives high
    assign pin_level_o = (pull_low_i || (!dev_oe_n_i && !dev_drive_i)) ? 1'b0 : 1'b1;
endmodule // rcdv_mcu_model

// file: dv/rcdv_top_properties.sv
// Port-level checks for rcdv_top.
// Assumes one clock domain and the one-cycle output latency of the design.
`include "rcdv_regs.vh"
module rcdv_top_props (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_waddr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic tx_rx_select_pin_i,
    input wire logic modulation_select_pin_i,
    input wire logic powerdown_detect_pin_i,
    input wire logic powerdown_detect_pin_o,
    input wire logic powerdown_detect_pin_oe_n_o,
    input wire logic front_amp_gain_sel_o,
    input wire logic [3:0] div_ratio_o,
    input wire logic amp_path_sel_o,
    input wire logic slicer_peak_sel_o,
    input wire logic [2:0] chan_bw_code_o,
    input wire logic [3:0] data_bw_code_o,
    input wire logic powerdown_o,
    input wire logic data_valid_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Lone writes only, so a following write cannot mask the field
    sequence main_wr;
        (reg_wr_i && reg_waddr_i == `RCDV_ADDR_MAIN) ##1 !reg_wr_i;
    endsequence
    sequence filt_wr;
        (reg_wr_i && reg_waddr_i == `RCDV_ADDR_FILT) ##1 !reg_wr_i;
    endsequence
    gain_field_a: assert property (main_wr |=>
        front_amp_gain_sel_o == $past(reg_wdata_i[4], 2)) else $error("gain select wrong");
    slicer_field_a: assert property (main_wr |=>
        slicer_peak_sel_o == $past(reg_wdata_i[15], 2)) else $error("slicer select wrong");
    chan_bw_a: assert property (filt_wr |=>
        chan_bw_code_o == $past(reg_wdata_i[3:1], 2)) else $error("channel bw wrong");
    data_bw_a: assert property (filt_wr |=>
        data_bw_code_o == $past(reg_wdata_i[7:4], 2)) else $error("data bw wrong");
    tx_divider_a: assert property ($rose(tx_rx_select_pin_i) |=> div_ratio_o == 4'h6)
        else $error("divider not 6 in transmit");
    amp_path_a: assert property ($rose(modulation_select_pin_i) |=> amp_path_sel_o)
        else $error("amplitude path not taken");
    pin_powerdown_a: assert property (powerdown_detect_pin_i |=> powerdown_o)
        else $error("pin high without power down");
    open_drain_a: assert property (powerdown_detect_pin_o == 1'b0)
        else $error("pin driven high");
    valid_pull_a: assert property (data_valid_o |-> !powerdown_detect_pin_oe_n_o)
        else $error("valid without pin pulled");
    cover property ($rose(data_valid_o));
    cover property ($fell(powerdown_detect_pin_oe_n_o) && !data_valid_o);
    cover property (main_wr ##1 powerdown_o);
endmodule // rcdv_top_props
bind rcdv_top rcdv_top_props u_rcdv_top_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_wr_i(reg_wr_i), .reg_waddr_i(reg_waddr_i), .reg_wdata_i(reg_wdata_i),
    .tx_rx_select_pin_i(tx_rx_select_pin_i), .modulation_select_pin_i(modulation_select_pin_i),
    .powerdown_detect_pin_i(powerdown_detect_pin_i),
    .powerdown_detect_pin_o(powerdown_detect_pin_o),
    .powerdown_detect_pin_oe_n_o(powerdown_detect_pin_oe_n_o),
    .front_amp_gain_sel_o(front_amp_gain_sel_o), .div_ratio_o(div_ratio_o),
    .amp_path_sel_o(amp_path_sel_o), .slicer_peak_sel_o(slicer_peak_sel_o),
    .chan_bw_code_o(chan_bw_code_o), .data_bw_code_o(data_bw_code_o),
    .powerdown_o(powerdown_o), .data_valid_o(data_valid_o));

// file: dv/rcdv_top_bench.sv
// Self-checking bench for rcdv_top: registers, pins, polling and timer modes.
// Assumes the decoded register port and a wire model with pull-up.
`include "rcdv_regs.vh"
module rcdv_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 0, sys_rst_i = 1, wr = 0, tx = 0, md = 0, sl = 0, run = 0, pull = 1;
    logic [7:0] wa = 0, ra = 0, rssi = 0;
    logic [15:0] wd = 0;
    logic [1:0] ph = 0;
    wire [15:0] rdata;
    wire pin_o, oe_n, gain, pa, amp, slc, pd, dv, pin_w;
    wire [3:0] div, dbw;
    wire [2:0] cbw;
    int err_total = 0, cmp_count = 0, n;
    rcdv_top u_rcdv_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr),
        .reg_waddr_i(wa), .reg_wdata_i(wd), .reg_raddr_i(ra), .reg_rdata_o(rdata),
        .tx_rx_select_pin_i(tx), .modulation_select_pin_i(md),
        .powerdown_detect_pin_i(pin_w), .powerdown_detect_pin_o(pin_o),
        .powerdown_detect_pin_oe_n_o(oe_n), .sliced_data_i(sl), .rssi_level_i(rssi),
        .front_amp_gain_sel_o(gain), .pa_high_power_o(pa), .div_ratio_o(div),
        .amp_path_sel_o(amp), .slicer_peak_sel_o(slc), .chan_bw_code_o(cbw),
        .data_bw_code_o(dbw), .powerdown_o(pd), .data_valid_o(dv));
    rcdv_mcu_model u_rcdv_mcu_model (.pull_low_i(pull), .dev_oe_n_i(oe_n),
        .dev_drive_i(pin_o), .pin_level_o(pin_w));
    always #2.5 clk_i = ~clk_i;
    // Sliced data with an 8-cycle period, inside the programmed window
    always @(posedge clk_i) begin
        if (run) begin
            ph <= ph + 2'd1;
            sl <= (ph == 2'd3) ? ~sl : sl;
        end
    end
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr <= 1;
        wa <= a;
        wd <= d;
        @(posedge clk_i);
        wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
        @(posedge clk_i);
        ra <= a;
        repeat (2) @(posedge clk_i);
        #1 chk(nm, rdata, e);
    endtask
    // Outputs lag a register write by two edges; three leaves margin
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    // Bounded wait on data valid (sel=1) or the pin enable (sel=0)
    task automatic wt(input bit sel, input logic lvl, output int c);
        c = 0;
        while ((sel ? dv : oe_n) !== lvl && c < 600) begin
            @(posedge clk_i);
            #1 c++;
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 0;
        rd(`RCDV_ADDR_MAIN, 16'h0011, "main reset");
        rd(`RCDV_ADDR_FILT, 16'h0000, "filter reset");
        rd(8'h05, 16'h0000, "unmapped read");
        chk("gain", gain, 1);
        chk("pa", pa, 1);
        chk("slicer", slc, 0);
        chk("div", div, `RCDV_DIV_RX);
        chk("pd", pd, 0);
        wrr(`RCDV_ADDR_MAIN, 16'h8010);
        settle();
        chk("slicer", slc, 1);
        wrr(`RCDV_ADDR_MAIN, 16'h4400);
        settle();
        chk("gain", gain, 0);
        chk("div", div, `RCDV_DIV_TX);
        chk("pd", pd, 1);
        rd(`RCDV_ADDR_MAIN, 16'h4400, "main in pd");
        wrr(`RCDV_ADDR_MAIN, 16'h0000);
        tx <= 1;
        md <= 1;
        settle();
        chk("div", div, `RCDV_DIV_TX);
        chk("amp", amp, 1);
        chk("pd", pd, 0);
        tx <= 0;
        md <= 0;
        wrr(`RCDV_ADDR_MAIN, 16'h0800);
        settle();
        chk("amp", amp, 1);
        chk("div", div, `RCDV_DIV_RX);
        wrr(`RCDV_ADDR_MAIN, 16'h0000);
        settle();
        chk("amp", amp, 0);
        for (int i = 0; i < 16; i++) begin
            wrr(`RCDV_ADDR_FILT, {8'h00, i[3:0], i[2:0], 1'b0});
            settle();
            chk("chan bw", cbw, i[2:0]);
            chk("data bw", dbw, i[3:0]);
        end
        pull <= 0;
        settle();
        chk("pd released", pd, 1);
        // Window opens at the true period, so a first edge counted from wake never
        // qualifies; the on phase spans several data periods to see a full one
        wrr(`RCDV_ADDR_WMIN, 16'h0008);
        wrr(`RCDV_ADDR_WMAX, 16'h000C);
        wrr(`RCDV_ADDR_RSSI, 16'h0040);
        wrr(`RCDV_ADDR_PER, 16'h0020);
        rssi <= 8'h50;
        run <= 1;
        wrr(`RCDV_ADDR_MODE, {14'h0, `RCDV_MODE_POLL});
        wt(1, 1, n);
        chk("valid", dv, 1);
        chk("oe_n", oe_n, 0);
        chk("wire", pin_w, 0);
        rd(`RCDV_ADDR_MEAS, 16'h0008, "period");
        rssi <= 8'h10;
        wt(1, 0, n);
        chk("valid drop", dv, 0);
        chk("oe_n drop", oe_n, 1);
        run <= 0;
        wrr(`RCDV_ADDR_MODE, {14'h0, `RCDV_MODE_TIMER});
        wt(0, 0, n);
        wt(0, 1, n);
        chk("pulse", n[15:0], `RCDV_TPULSE_CYC);
        wrr(`RCDV_ADDR_MODE, {14'h0, `RCDV_MODE_SLAVE});
        repeat (50) @(posedge clk_i);
        #1 chk("slave oe_n", oe_n, 1);
        give_verdict();
    end
endmodule // rcdv_top_bench
